// File: include/conv_pkg.sv
// Constants and types shared by the converter result and trigger logic
package conv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  // Register offsets
  localparam logic [7:0] OFF_RESULT_LOW = 8'h78;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h79;
  localparam logic [7:0] OFF_TRIGGER_CONTROL = 8'h7B;
  localparam logic [7:0] OFF_DIGITAL_INPUT_DISABLE = 8'h7E;
  localparam logic [7:0] OFF_CONTROL = 8'h7A;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h70;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h71;
  // Field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_START_BIT = 6;
  localparam int CTL_AUTO_BIT = 5;
  localparam int CTL_LEFT_BIT = 4;
  localparam int TRG_CMP_MUX_BIT = 6;
  localparam logic [7:0] TRG_WRITABLE = 8'h47;
  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;
  localparam int IRQ_W = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // Trigger source encodings
  typedef enum logic [2:0] {
    SRC_FREE = 3'h0,
    SRC_COMPARATOR = 3'h1,
    SRC_EXT_IRQ0 = 3'h2,
    SRC_T0_CMP_A = 3'h3,
    SRC_T0_OVF = 3'h4,
    SRC_T1_CMP_B = 3'h5,
    SRC_T1_OVF = 3'h6,
    SRC_T1_CAPTURE = 3'h7
  } trigger_source_t;
endpackage : conv_pkg

// File: rtl/conv_result_ctrl.sv
// Converter result registers, alignment, auto-trigger and input disable
`timescale 1ns/1ps
// Operation
// - A finished conversion lands its 10-bit result across the low and high result bytes, two's complement for differential channels.
// - Once the low byte is read, neither byte updates until the high byte is read.
// - Left alignment puts result 9:2 in the high byte and 1:0 in low bits 7:6, the rest zero.
// - Right alignment, the reset default, puts result 7:0 in the low byte and 9:8 in high bits 1:0.
// - Trigger control bits 7 and 5:3 read zero and software writes them zero.
// - The trigger source field acts only while auto trigger is enabled.
// - In auto trigger with the converter enabled, a rising edge of the selected flag starts a conversion.
// - Switching from a clear source to a set source other than free running is an edge and starts a conversion when enabled.
// - Selecting free running never by itself makes a trigger event.
// - Source codes are free running, comparator, external irq 0, timer0 match A, timer0 overflow, timer1 match B, timer1 overflow, timer1 capture.
// - Each set input disable bit turns off its pin buffer and forces its port bit to zero.
// - Result bytes are read-only and zero after reset.
// - Changing left alignment changes the result presentation at once.
// - The done flag sets when a conversion finishes and results update; its edge drives free running.
module conv_result_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [conv_pkg::ADDR_W-1:0] addr,
  input wire logic [conv_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [conv_pkg::DATA_W-1:0] rdata,
  input wire logic conv_done,
  input wire logic [conv_pkg::RES_W-1:0] conv_result,
  input wire logic comparator_flag,
  input wire logic ext_irq0_flag,
  input wire logic t0_cmp_a_flag,
  input wire logic t0_ovf_flag,
  input wire logic t1_cmp_b_flag,
  input wire logic t1_ovf_flag,
  input wire logic t1_capture_flag,
  input wire logic [7:0] pin_level,
  output logic [7:0] port_input,
  output logic [7:0] buffer_enable,
  output logic conversion_start,
  output logic comparator_mux_enable,
  output logic irq
);
  import conv_pkg::*;

  typedef struct packed {
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] pending;
    logic pending_valid;
    logic locked;
    logic converter_enable;
    logic auto_trigger_enable;
    logic left_align;
    logic done_flag;
    logic comparator_mux_enable;
    trigger_source_t trigger_source;
    logic [7:0] digital_input_disable;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] rdata;
    logic [7:0] port_input;
    logic [7:0] buffer_enable;
    logic start;
    logic irq;
  } state_t;

  state_t q;
  state_t next_q;
  logic trig_pulse;
  logic [7:0] source_flags;
  logic [7:0] low_view;
  logic [7:0] high_view;

  // Byte views of the result for a given alignment
  function automatic logic [7:0] view_low(input logic [RES_W-1:0] r, input logic left);
    view_low = left ? {r[1:0], 6'h00} : r[7:0];
  endfunction : view_low

  function automatic logic [7:0] view_high(input logic [RES_W-1:0] r, input logic left);
    view_high = left ? r[9:2] : {6'h00, r[9:8]};
  endfunction : view_high

  // Flags indexed by trigger code; slot 0 is the done flag for free running
  assign source_flags = {t1_capture_flag, t1_ovf_flag, t1_cmp_b_flag, t0_ovf_flag,
                         t0_cmp_a_flag, ext_irq0_flag, comparator_flag, q.done_flag};

  trigger_select u_trigger (
    .clk(clk),
    .resetn(resetn),
    .trigger_source(q.trigger_source),
    .auto_trigger_enable(q.auto_trigger_enable),
    .converter_enable(q.converter_enable),
    .source_flags(source_flags),
    .start_pulse(trig_pulse)
  );

  // Views follow the live alignment bit
  assign low_view = view_low(q.result, q.left_align);
  assign high_view = view_high(q.result, q.left_align);

  // Next-state logic
  always_comb begin
    next_q = q;
    next_q.start = 1'b0;
    next_q.rdata = 8'h00;
    // Result capture; held back while the pair is locked
    if (conv_done) begin
      next_q.done_flag = 1'b1;
      if (q.locked) begin
        next_q.pending = conv_result;
        next_q.pending_valid = 1'b1;
      end else begin
        next_q.result = conv_result;
      end
    end
    // Register reads
    if (rd) begin
      unique case (addr)
        OFF_RESULT_LOW: begin
          next_q.rdata = low_view;
          next_q.locked = 1'b1;
          // A result landing with the low read waits for the high read
          if (conv_done && !q.locked) begin
            next_q.result = q.result;
            next_q.pending = conv_result;
            next_q.pending_valid = 1'b1;
          end
        end
        OFF_RESULT_HIGH: begin
          next_q.rdata = high_view;
          next_q.locked = 1'b0;
          if (q.pending_valid && !conv_done) begin
            next_q.result = q.pending;
            next_q.pending_valid = 1'b0;
          end else if (conv_done) begin
            next_q.result = conv_result;
            next_q.pending_valid = 1'b0;
          end
        end
        OFF_TRIGGER_CONTROL: begin
          next_q.rdata = {1'b0, q.comparator_mux_enable, 3'h0, q.trigger_source};
        end
        OFF_CONTROL: begin
          next_q.rdata = {q.converter_enable, 1'b0, q.auto_trigger_enable, q.left_align,
                          3'h0, q.done_flag};
        end
        OFF_DIGITAL_INPUT_DISABLE: next_q.rdata = q.digital_input_disable;
        OFF_IRQ_STATUS: begin
          next_q.rdata = {6'h00, q.irq_status};
          next_q.irq_status = '0;
        end
        OFF_IRQ_MASK: next_q.rdata = {6'h00, q.irq_mask};
        default: next_q.rdata = 8'h00;
      endcase
    end
    // Register writes; result bytes ignore writes
    if (wr) begin
      unique case (addr)
        OFF_TRIGGER_CONTROL: begin
          next_q.comparator_mux_enable = wdata[TRG_CMP_MUX_BIT];
          next_q.trigger_source = trigger_source_t'(wdata[2:0]);
        end
        OFF_CONTROL: begin
          next_q.converter_enable = wdata[CTL_ENABLE_BIT];
          next_q.auto_trigger_enable = wdata[CTL_AUTO_BIT];
          next_q.left_align = wdata[CTL_LEFT_BIT];
          next_q.start = wdata[CTL_START_BIT] & wdata[CTL_ENABLE_BIT];
          if (wdata[0] && !conv_done) next_q.done_flag = 1'b0;
        end
        OFF_DIGITAL_INPUT_DISABLE: next_q.digital_input_disable = wdata;
        OFF_IRQ_MASK: next_q.irq_mask = wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Sticky events; a set beats a same-cycle clear
    if (conv_done) next_q.irq_status[IRQ_DONE_BIT] = 1'b1;
    if (trig_pulse) next_q.irq_status[IRQ_TRIG_BIT] = 1'b1;
    if (trig_pulse) next_q.start = 1'b1;
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);
    // Disabled pins read zero and lose their buffer
    next_q.port_input = pin_level & ~q.digital_input_disable;
    next_q.buffer_enable = ~q.digital_input_disable;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.buffer_enable <= 8'hFF;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign port_input = q.port_input;
  assign buffer_enable = q.buffer_enable;
  assign conversion_start = q.start;
  assign comparator_mux_enable = q.comparator_mux_enable;
  assign irq = q.irq;
endmodule : conv_result_ctrl

// File: rtl/trigger_select.sv
// Trigger source selector with rising-edge start detection
`timescale 1ns/1ps
module trigger_select (
  input wire logic clk,
  input wire logic resetn,
  input wire conv_pkg::trigger_source_t trigger_source,
  input wire logic auto_trigger_enable,
  input wire logic converter_enable,
  input wire logic [7:0] source_flags,
  output logic start_pulse
);
  import conv_pkg::*;

  typedef struct packed {
    logic prev_level;
    trigger_source_t prev_source;
    logic start_pulse;
  } state_t;

  state_t q;
  state_t next_q;
  logic level;
  logic to_free;

  // Selected flag; free running uses the conversion done flag in slot 0
  always_comb begin
    level = source_flags[trigger_source];
    // A switch into free running must not fire on an already set done flag
    to_free = (trigger_source == SRC_FREE) && (q.prev_source != SRC_FREE);
    next_q = q;
    next_q.prev_level = level;
    next_q.prev_source = trigger_source;
    // Edge against last cycle's selected level, so a source switch acts as an edge
    next_q.start_pulse = auto_trigger_enable & converter_enable & level & ~q.prev_level
                         & ~to_free;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign start_pulse = q.start_pulse;
endmodule : trigger_select

// File: tb/conv_result_ctrl_properties.sv
// Port assertions for the converter result block
`timescale 1ns/1ps
module conv_result_ctrl_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic conv_done,
  input wire logic t0_ovf_flag,
  input wire logic [7:0] port_input,
  input wire logic [7:0] buffer_enable,
  input wire logic conversion_start
);
  logic [7:0] ctl, trg;
  logic seen;
  wire sw = wr && addr == 8'h7A && wdata[6];
  // Shadow of control, trigger select and first result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl <= 8'h00;
      trg <= 8'h00;
      seen <= 1'b0;
    end else begin
      if (wr && addr == 8'h7A) ctl <= wdata;
      if (wr && addr == 8'h7B) trg <= wdata;
      if (conv_done) seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_trg_reserved: assert property (rd && addr == 8'h7B |=> (rdata & 8'hB8) == 8'h00)
    else $error("reserved trigger bits read nonzero");
  chk_high_right: assert property (rd && addr == 8'h79 && !ctl[4] |=> rdata[7:2] == 6'h00)
    else $error("right aligned high byte upper bits nonzero");
  chk_low_left: assert property (rd && addr == 8'h78 && ctl[4] |=> rdata[5:0] == 6'h00)
    else $error("left aligned low byte lower bits nonzero");
  chk_result_reset: assert property (rd && addr[7:1] == 7'h3C && !seen |=> rdata == 8'h00)
    else $error("result byte nonzero before any conversion");
  chk_port_masked: assert property ($stable(buffer_enable) |-> (port_input & ~buffer_enable) == 8'h00)
    else $error("disabled pin reads nonzero");
  chk_buffer_write: assert property (wr && addr == 8'h7E ##1 !(wr && addr == 8'h7E) ##1 1'b1
    |-> buffer_enable == ~$past(wdata, 2)) else $error("buffer enables do not follow disable bits");
  chk_start_edge: assert property (ctl[7] && ctl[5] && trg[2:0] == 3'h4 && $rose(t0_ovf_flag)
    && $stable(trg) |-> ##[1:2] conversion_start) else $error("no start after selected flag rise");
  chk_no_auto: assert property (conversion_start |-> $past(ctl[5]) || $past(ctl[5], 2) || $past(sw))
    else $error("start without auto trigger or software start");
  cover property (conversion_start);
  cover property (rd && addr == 8'h78 && ctl[4]);
  cover property (conv_done ##1 rd);
endmodule : conv_result_ctrl_properties
bind conv_result_ctrl conv_result_ctrl_properties i_conv_result_ctrl_properties (.clk, .resetn,
  .addr, .wdata, .wr, .rd, .rdata, .conv_done, .t0_ovf_flag, .port_input, .buffer_enable,
  .conversion_start);

// File: tb/conv_result_ctrl_tb.sv
// Self-checking bench for the converter result block
`timescale 1ns/1ps
module conv_result_ctrl_tb;
  import conv_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, conv_done = 0, conversion_start, irq;
  logic [7:0] addr = 0, wdata = 0, pin_level = 0, rdata, port_input, buffer_enable, got;
  logic [9:0] conv_result = 0;
  logic [6:0] fl = 0;
  logic [7:0] ra[5] = '{8'h78, 8'h79, 8'h7B, 8'h7E, 8'h7F};
  int fails = 0, comparisons = 0, res = 0, pend = -1, lock = 0, left = 0, d;
  // Free running clock
  always #10 clk = ~clk;
  conv_result_ctrl i_conv_result_ctrl (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .conv_done,
    .conv_result, .comparator_flag(fl[0]), .ext_irq0_flag(fl[1]), .t0_cmp_a_flag(fl[2]),
    .t0_ovf_flag(fl[3]), .t1_cmp_b_flag(fl[4]), .t1_ovf_flag(fl[5]), .t1_capture_flag(fl[6]),
    .pin_level, .port_input, .buffer_enable, .conversion_start, .comparator_mux_enable(), .irq);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic put(logic [7:0] a, logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask : put
  task automatic get(logic [7:0] a);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    got = rdata;
    @(posedge clk);
  endtask : get
  task automatic conv(int v);
    conv_result <= v[9:0];
    conv_done <= 1;
    @(posedge clk);
    conv_done <= 0;
    if (lock) pend = v; else res = v;
    @(posedge clk);
  endtask : conv
  // Read one result byte against the model, then lock or unlock
  task automatic rres(logic [7:0] a);
    get(a);
    chk("result", a[0] ? (left ? res[9:2] : {6'h0, res[9:8]})
      : (left ? {res[1:0], 6'h0} : res[7:0]), got);
    if (a[0]) begin
      lock = 0;
      if (pend >= 0) res = pend;
      pend = -1;
    end else lock = 1;
  endtask : rres
  task automatic wstart(logic e);
    logic s = 0;
    repeat (4) begin
      @(posedge clk);
      s |= conversion_start;
    end
    chk("start", {7'h0, e}, {7'h0, s});
  endtask : wstart
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    d = $urandom(32'h184e4581);
    repeat (3) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    put(8'h78, 8'hFF);
    put(8'h79, 8'hFF);
    foreach (ra[i]) begin
      get(ra[i]);
      chk("reset", 8'h00, got);
    end
    $display("test reset done");
    for (int l = 0; l < 2; l++) begin
      left = l;
      put(8'h7A, {3'h0, l[0], 4'h0});
      rres(8'h78);
      conv($urandom_range(1023));
      rres(8'h79);
      rres(8'h79);
      rres(8'h78);
      rres(8'h79);
    end
    $display("test result done");
    put(8'h7B, 8'h47);
    get(8'h7B);
    chk("trigger", 8'h47, got);
    put(8'h7B, 8'h00);
    put(8'h7A, 8'h01);
    put(8'h7A, 8'hA0);
    for (int s = 1; s < 8; s++) begin
      put(8'h7B, s[7:0]);
      fl[s-1] <= 1;
      wstart(1);
      fl[s-1] <= 0;
    end
    put(8'h7A, 8'h80);
    put(8'h7B, 8'h03);
    fl[2] <= 1;
    wstart(0);
    fl[2] <= 0;
    put(8'h7A, 8'hA0);
    fl[3] <= 1;
    wstart(0);
    put(8'h7B, 8'h04);
    wstart(1);
    conv($urandom_range(1023));
    fl[3] <= 0;
    put(8'h7B, 8'h00);
    wstart(0);
    put(8'h7A, 8'h00);
    $display("test trigger done");
    d = $urandom;
    put(8'h7E, d[7:0]);
    pin_level <= d[15:8];
    repeat (2) @(posedge clk);
    chk("port", d[15:8] & ~d[7:0], port_input);
    chk("buffer", ~d[7:0], buffer_enable);
    get(8'h7E);
    chk("disable", d[7:0], got);
    $display("test disable done");
    put(8'h71, 8'h01);
    get(8'h70);
    conv($urandom_range(1023));
    chk("irq", 8'h01, {7'h0, irq});
    get(8'h70);
    chk("status", 8'h01, got & 8'h01);
    @(posedge clk);
    chk("irq", 8'h00, {7'h0, irq});
    put(8'h71, 8'h00);
    conv($urandom_range(1023));
    chk("irq", 8'h00, {7'h0, irq});
    $display("test interrupt done");
    print_verdict();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule : conv_result_ctrl_tb
